// *** rtl/ebu_ctrl.v ***
// External bus cycle controller: windows, reset straps and bus cycle sequencer.
// Contract
// - Single chip plus four external bus modes.
// - Four windows; misses use default configuration.
// - Window configuration sets mode, width, timing.
// - External access pin high clears default configuration except ALECTL and bus type.
// - Single chip: no external access, ports free; active windows still go out, a demux window still drives the address port.
// - Demux: address port; mux: muxed port, plus address port while any demux is configured.
// - Bus taken only when bus active set.
// - Pin low: bus type loaded, later writable.
// - Intra-segment address on muxed or address port.
// - Segment lines eight, four, two, none.
// - Segmentation disabled: no segment lines.
// - Segmentation disable decides pointer save.
// - 8-bit mux keeps A15-A8 steady.
// - Segment lines stay driven whole cycle.
// - Mux: strobe, address, removal, then command.
// - Read data latched before command ends.
// - Write data held until next cycle.
// - Demux command after programmable address delay.
// - Demux write followed by next address.
// - Read and write strobes high in reset, and in hold while idle.
// - Enabled ready input terminates the cycle.
`timescale 1ns/10ps
`include "ebu_defines.vh"

module ebu_ctrl
#(
	parameter NWIN = 4
)
(
	// Clock, reset and clock enable
	input  wire               CLK,
	input  wire               RESET,
	input  wire               CE,
	// Request port from the core
	input  wire               REQ,
	input  wire [23:0]        REQ_ADDR,
	input  wire               REQ_WRITE,
	input  wire [1:0]         REQ_BE,
	input  wire [15:0]        REQ_WDATA,
	output reg                REQ_READY,
	output reg                ACK,
	output reg                ERR,
	output reg  [15:0]        RDATA,
	// Configuration and status
	input  wire [NWIN*16-1:0] WIN_CFG,
	input  wire [NWIN*16-1:0] WIN_SEL,
	input  wire               DEF_CFG_WR,
	input  wire [15:0]        DEF_CFG_WDATA,
	output reg  [15:0]        DEF_CFG,
	input  wire               SGT_DIS,
	output reg                SAVE_CSP,
	output reg                SINGLE_CHIP,
	// Bus pins
	input  wire               EA_N,
	input  wire               HOLD,
	input  wire               READY_N,
	input  wire [15:0]        P0_IN,
	output reg  [15:0]        P0_OUT,
	output reg  [1:0]         P0_OE,
	output reg  [15:0]        P1_OUT,
	output reg                P1_OE,
	output reg  [7:0]         P4_OUT,
	output reg  [7:0]         P4_OE,
	output reg                ALE,
	output reg                RD_N,
	output reg                WR_N,
	output reg                WRH_N,
	output reg  [NWIN-1:0]    CS_N
);

// ============================================================
// State codes
localparam S_IDLE = 2'h0;
localparam S_ALE  = 2'h1;
localparam S_ADRH = 2'h2;
localparam S_CMD  = 2'h3;

// ============================================================
// Pin synchronisers
reg  [15:0] p0_m_r;
reg  [15:0] p0_s_r;
reg  [2:0]  pin_m_r;
reg  [2:0]  pin_s_r;
wire        ea_n_s  = pin_s_r[0];
wire        hold_s  = pin_s_r[1];
wire        ready_s = ~pin_s_r[2];

always @(posedge CLK or posedge RESET)
begin
	if (RESET)
	begin
		p0_m_r  <= 16'h0000;
		p0_s_r  <= 16'h0000;
		pin_m_r <= 3'h7;
		pin_s_r <= 3'h7;
	end
	else if (CE)
	begin
		p0_m_r  <= P0_IN;
		p0_s_r  <= p0_m_r;
		pin_m_r <= {READY_N, HOLD, EA_N};
		pin_s_r <= pin_m_r;
	end
end

// ============================================================
// Window decode
wire [NWIN-1:0] hit;
wire [NWIN-1:0] win_demux;
genvar gi;
generate
	for (gi = 0; gi < NWIN; gi = gi + 1)
	begin : g_win
		wire [15:0] sel  = WIN_SEL[gi*16 +: 16];
		wire [15:0] cfg  = WIN_CFG[gi*16 +: 16];
		wire [11:0] mask = 12'hFFF << sel[`EBU_SEL_SIZE_HI:`EBU_SEL_SIZE_LO];
		assign hit[gi] = cfg[`EBU_CFG_BUSACT] &&
			((REQ_ADDR[23:12] & mask) == (sel[`EBU_SEL_BASE_HI:`EBU_SEL_BASE_LO] & mask));
		assign win_demux[gi] = cfg[`EBU_CFG_BUSACT] && !cfg[`EBU_CFG_BUS_TYPE_FIELD_LO];
	end
endgenerate

// Lowest numbered window wins when windows overlap.
reg [15:0]     sel_cfg;
reg [NWIN-1:0] sel_onehot;
integer        k;
always @*
begin
	sel_cfg    = DEF_CFG;
	sel_onehot = {NWIN{1'b0}};
	for (k = NWIN - 1; k >= 0; k = k - 1)
	begin
		if (hit[k])
		begin
			sel_cfg    = WIN_CFG[k*16 +: 16];
			sel_onehot = {NWIN{1'b0}};
			sel_onehot[k] = 1'b1;
		end
	end
end

// ============================================================
// Straps and segment mask
reg        strap_done_r;
reg [1:0]  strap_cnt_r;
reg [1:0]  segment_lines_select_r;
reg [1:0]  chip_select_count_r;
reg [7:0]  seg_mask;
reg [NWIN-1:0] cs_allow;

always @*
begin
	case (segment_lines_select_r)
		`EBU_SAL_EIGHT: seg_mask = 8'hFF;
		`EBU_SAL_FOUR:  seg_mask = 8'h0F;
		`EBU_SAL_TWO:   seg_mask = 8'h03;
		default:        seg_mask = 8'h00;
	endcase
	if (SGT_DIS)
		seg_mask = 8'h00;
	case (chip_select_count_r)
		2'h1:    cs_allow = {{(NWIN-2){1'b0}}, 2'h3};
		2'h2:    cs_allow = {{(NWIN-3){1'b0}}, 3'h7};
		2'h3:    cs_allow = {NWIN{1'b1}};
		default: cs_allow = {NWIN{1'b0}};
	endcase
end

wire       any_demux = (|win_demux) || (DEF_CFG[`EBU_CFG_BUSACT] && !DEF_CFG[`EBU_CFG_BUS_TYPE_FIELD_LO]);
wire       ext_ok    = sel_cfg[`EBU_CFG_BUSACT];
wire       sel_8bit  = !sel_cfg[`EBU_CFG_BUS_TYPE_FIELD_HI];
wire       sel_mux   = sel_cfg[`EBU_CFG_BUS_TYPE_FIELD_LO];

// ============================================================
// Cycle sequencer
reg [1:0]  state_r;
reg [15:0] cfg_r;
reg [23:0] addr_r;
reg        write_r;
reg [1:0]  be_r;
reg [15:0] wdata_r;
reg        hi_r;
reg        second_r;
reg        ext_r;
reg [3:0]  ws_r;
reg [15:0] p0_nxt;

wire       cyc_mux  = cfg_r[`EBU_CFG_BUS_TYPE_FIELD_LO];
wire       cyc_8bit = !cfg_r[`EBU_CFG_BUS_TYPE_FIELD_HI];

always @*
begin
	if (cyc_8bit)
		p0_nxt = {addr_r[15:8], hi_r ? wdata_r[15:8] : wdata_r[7:0]};
	else if (be_r == 2'h2)
		p0_nxt = {wdata_r[15:8], wdata_r[15:8]};
	else if (be_r == 2'h1)
		p0_nxt = {wdata_r[7:0], wdata_r[7:0]};
	else
		p0_nxt = wdata_r;
end

always @(posedge CLK or posedge RESET)
begin
	if (RESET)
	begin
		state_r      <= S_IDLE;
		strap_done_r <= 1'b0;
		strap_cnt_r  <= 2'h0;
		segment_lines_select_r     <= `EBU_SAL_NONE;
		chip_select_count_r      <= 2'h0;
		DEF_CFG      <= `EBU_DEF_SINGLE;
		SINGLE_CHIP  <= 1'b1;
		SAVE_CSP     <= 1'b0;
		cfg_r        <= 16'h0000;
		addr_r       <= 24'h000000;
		write_r      <= 1'b0;
		be_r         <= 2'h0;
		wdata_r      <= 16'h0000;
		hi_r         <= 1'b0;
		second_r     <= 1'b0;
		ext_r        <= 1'b0;
		ws_r         <= 4'h0;
		REQ_READY    <= 1'b0;
		ACK          <= 1'b0;
		ERR          <= 1'b0;
		RDATA        <= 16'h0000;
		P0_OUT       <= 16'h0000;
		P0_OE        <= 2'h0;
		P1_OUT       <= 16'h0000;
		P1_OE        <= 1'b0;
		P4_OUT       <= 8'h00;
		P4_OE        <= 8'h00;
		ALE          <= 1'b0;
		RD_N         <= 1'b1;
		WR_N         <= 1'b1;
		WRH_N        <= 1'b1;
		CS_N         <= {NWIN{1'b1}};
	end
	else if (CE)
	begin
		ACK <= 1'b0;
		ERR <= 1'b0;
		SAVE_CSP <= !SGT_DIS;
		// The straps are read only once the synchronisers hold settled pin levels.
		if (!strap_done_r)
		begin
			if (strap_cnt_r == `EBU_STRAP_WAIT)
			begin
				strap_done_r <= 1'b1;
				segment_lines_select_r     <= p0_s_r[`EBU_RST_SEGMENT_LINES_SELECT_HI:`EBU_RST_SEGMENT_LINES_SELECT_LO];
				chip_select_count_r      <= p0_s_r[`EBU_RST_CHIP_SELECT_COUNT_HI:`EBU_RST_CHIP_SELECT_COUNT_LO];
				SINGLE_CHIP  <= ea_n_s;
				// Pin high clears all but keeps bus type and sets the lengthened latch strobe.
				// Pin low loads bus type, bus active.
				DEF_CFG <= (ea_n_s ? `EBU_DEF_SINGLE : `EBU_DEF_EXTERNAL) |
					{8'h00, p0_s_r[`EBU_RST_BUS_TYPE_FIELD_HI:`EBU_RST_BUS_TYPE_FIELD_LO], 6'h00};
			end
			else
				strap_cnt_r <= strap_cnt_r + 2'h1;
		end
		else if (DEF_CFG_WR)
		begin
			DEF_CFG     <= DEF_CFG_WDATA;
			SINGLE_CHIP <= !DEF_CFG_WDATA[`EBU_CFG_BUSACT] && !(|win_demux);
		end
		// Address port owned while any demux is configured.
		P1_OE <= strap_done_r && any_demux;
		case (state_r)
			S_IDLE:
			begin
				REQ_READY <= strap_done_r && !hold_s;
				if (REQ && REQ_READY)
				begin
					// Only active configurations reach the pins.
					if (!ext_ok || hold_s)
					begin
						ACK       <= 1'b1;
						ERR       <= 1'b1;
						REQ_READY <= 1'b0;
					end
					else
					begin
						// Cycle shape taken from the selected configuration.
						cfg_r     <= sel_cfg;
						addr_r    <= SGT_DIS ? {8'h00, REQ_ADDR[15:0]} : REQ_ADDR;
						write_r   <= REQ_WRITE;
						be_r      <= REQ_BE;
						wdata_r   <= REQ_WDATA;
						hi_r      <= sel_8bit && (REQ_BE == 2'h2);
						second_r  <= sel_8bit && (REQ_BE == 2'h3);
						ext_r     <= sel_cfg[`EBU_CFG_ALECTL];
						REQ_READY <= 1'b0;
						CS_N      <= ~(sel_onehot & cs_allow & {NWIN{sel_cfg[`EBU_CFG_CSEN]}});
						state_r   <= S_ALE;
						ALE       <= 1'b1;
						P1_OUT    <= {REQ_ADDR[15:1], sel_8bit ? (REQ_BE == 2'h2) : REQ_ADDR[0]};
						P4_OUT    <= (SGT_DIS ? 8'h00 : REQ_ADDR[23:16]) & seg_mask;
						P4_OE     <= seg_mask;
						if (sel_mux)
						begin
							// Address driven with the latch strobe.
							P0_OUT <= {REQ_ADDR[15:1], sel_8bit ? (REQ_BE == 2'h2) : REQ_ADDR[0]};
							P0_OE  <= 2'h3;
						end
						else
							P0_OE  <= 2'h0;
					end
				end
			end
			S_ALE:
			begin
				// Lengthened latch strobe adds one cycle.
				if (ext_r)
					ext_r <= 1'b0;
				else
				begin
					ALE <= 1'b0;
					if (cyc_mux || cfg_r[`EBU_CFG_RWDLY])
						state_r <= S_ADRH;
					else
					begin
						state_r <= S_CMD;
						ws_r    <= cfg_r[`EBU_CFG_WS_HI:`EBU_CFG_WS_LO];
						RD_N    <= write_r;
						WR_N    <= !(write_r && (cyc_8bit || be_r[0]));
						WRH_N   <= !(write_r && !cyc_8bit && be_r[1]);
						P0_OUT  <= p0_nxt;
						P0_OE   <= write_r ? (cyc_8bit ? 2'h1 : 2'h3) : 2'h0;
					end
				end
			end
			S_ADRH:
			begin
				state_r <= S_CMD;
				ws_r    <= cfg_r[`EBU_CFG_WS_HI:`EBU_CFG_WS_LO];
				RD_N    <= write_r;
				WR_N    <= !(write_r && (cyc_8bit || be_r[0]));
				WRH_N   <= !(write_r && !cyc_8bit && be_r[1]);
				P0_OUT  <= p0_nxt;
				// 8-bit mux keeps the high address byte driven.
				if (cyc_mux && cyc_8bit)
					P0_OE <= write_r ? 2'h3 : 2'h2;
				else
					P0_OE <= write_r ? (cyc_8bit ? 2'h1 : 2'h3) : 2'h0;
			end
			default:
			begin
				if (ws_r != 4'h0)
					ws_r <= ws_r - 4'h1;
				// Ready ends the cycle when enabled.
				else if (!cfg_r[`EBU_CFG_RDYEN] || ready_s)
				begin
					RD_N  <= 1'b1;
					WR_N  <= 1'b1;
					WRH_N <= 1'b1;
					// Read data captured with strobe release.
					if (!write_r)
					begin
						P0_OE <= (cyc_mux && cyc_8bit) ? 2'h2 : 2'h0;
						if (!cyc_8bit)
							RDATA <= p0_s_r;
						else if (hi_r)
							RDATA[15:8] <= p0_s_r[7:0];
						else
							RDATA[7:0] <= p0_s_r[7:0];
					end
					// Write data stays until the next cycle.
					if (second_r)
					begin
						// Word on a byte bus: low byte first, then high.
						second_r <= 1'b0;
						hi_r     <= 1'b1;
						ext_r    <= cfg_r[`EBU_CFG_ALECTL];
						state_r  <= S_ALE;
						ALE      <= 1'b1;
						// Next address follows a demux write.
						P1_OUT   <= {addr_r[15:1], 1'b1};
						if (cyc_mux)
						begin
							P0_OUT <= {addr_r[15:1], 1'b1};
							P0_OE  <= 2'h3;
						end
					end
					else
					begin
						ACK       <= 1'b1;
						CS_N      <= {NWIN{1'b1}};
						state_r   <= S_IDLE;
						REQ_READY <= 1'b0;
					end
				end
			end
		endcase
		// Hold keeps the strobes inactive while idle.
		if (hold_s && state_r == S_IDLE)
		begin
			RD_N  <= 1'b1;
			WR_N  <= 1'b1;
			WRH_N <= 1'b1;
		end
	end
end

endmodule

// *** rtl/ebu_defines.vh ***
// Constants for the external bus cycle controller.
`ifndef EBU_DEFINES_VH
`define EBU_DEFINES_VH

// ============================================================
// Bus configuration register fields
`define EBU_CFG_WS_HI      3
`define EBU_CFG_WS_LO      0
`define EBU_CFG_RWDLY      5
`define EBU_CFG_BUS_TYPE_FIELD_LO    6
`define EBU_CFG_BUS_TYPE_FIELD_HI    7
`define EBU_CFG_ALECTL     9
`define EBU_CFG_BUSACT     10
`define EBU_CFG_RDYEN      12
`define EBU_CFG_CSEN       14

// ============================================================
// Bus type encodings
`define EBU_BT_8_DEMUX     2'h0
`define EBU_BT_8_MUX       2'h1
`define EBU_BT_16_DEMUX    2'h2
`define EBU_BT_16_MUX      2'h3

// ============================================================
// Default configuration values after reset
`define EBU_DEF_SINGLE     16'h0200
`define EBU_DEF_EXTERNAL   16'h060F

// ============================================================
// Window select register fields
`define EBU_SEL_SIZE_HI    3
`define EBU_SEL_SIZE_LO    0
`define EBU_SEL_BASE_HI    15
`define EBU_SEL_BASE_LO    4

// ============================================================
// Reset configuration latch fields on the muxed port
`define EBU_RST_BUS_TYPE_FIELD_HI    7
`define EBU_RST_BUS_TYPE_FIELD_LO    6
`define EBU_RST_CHIP_SELECT_COUNT_HI   10
`define EBU_RST_CHIP_SELECT_COUNT_LO   9
`define EBU_RST_SEGMENT_LINES_SELECT_HI  12
`define EBU_RST_SEGMENT_LINES_SELECT_LO  11

// ============================================================
// Segment line select codes
`define EBU_SAL_FOUR       2'h0
`define EBU_SAL_NONE       2'h1
`define EBU_SAL_EIGHT      2'h2
`define EBU_SAL_TWO        2'h3

// Cycles the input synchronisers need before the straps are valid.
`define EBU_STRAP_WAIT     2'h2

`endif

// *** sim/ebu_ctrl_checker.sv ***
// Concurrent checks on the pins of the bus controller.
`timescale 1ns/10ps
module ebu_ctrl_checker
(
	// Clock and reset
	input wire        CLK,
	input wire        RESET,
	input wire        CE,
	// Request side
	input wire        ACK,
	input wire        ERR,
	input wire        SGT_DIS,
	input wire        SAVE_CSP,
	// Bus pins
	input wire [1:0]  P0_OE,
	input wire [15:0] P0_OUT,
	input wire [7:0]  P4_OUT,
	input wire        ALE,
	input wire        RD_N,
	input wire        WR_N,
	input wire        WRH_N
);
	// ============================================================
	// Properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_rst_idle;
		disable iff (1'b0) RESET |-> RD_N && WR_N && WRH_N;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("strobe active in reset");
	property p_one_cmd;
		!(!RD_N && !(WR_N && WRH_N));
	endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("read and write together");
	property p_err_quiet;
		ERR |-> ACK && RD_N && WR_N && WRH_N && !ALE;
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("refusal with bus activity");
	property p_rd_free;
		!RD_N |-> P0_OE[0] == 1'b0 && (P0_OE[1] == 1'b0 || P0_OUT[15:8] == $past(P0_OUT[15:8]));
	endproperty
	a_rd_free: assert property (p_rd_free) else $error("port driven during read");
	property p_rd_done;
		$rose(RD_N) |-> ##[0:40] ACK;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read without completion");
	property p_wr_hold;
		($rose(WR_N) || $rose(WRH_N)) && !ALE |-> P0_OE == $past(P0_OE) && P0_OUT == $past(P0_OUT);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write data dropped");
	property p_cmd_late;
		$fell(RD_N) || $fell(WR_N) || $fell(WRH_N) |-> !ALE;
	endproperty
	a_cmd_late: assert property (p_cmd_late) else $error("command during latch strobe");
	property p_seg_hold;
		!RD_N && !$past(RD_N) |-> $stable(P4_OUT);
	endproperty
	a_seg_hold: assert property (p_seg_hold) else $error("segment lines moved");
	property p_csp;
		!$past(RESET) && $past(CE) |-> SAVE_CSP == !$past(SGT_DIS);
	endproperty
	a_csp: assert property (p_csp) else $error("pointer save flag wrong");
endmodule

bind ebu_ctrl ebu_ctrl_checker ebu_ctrl_checker_inst (.CLK(CLK), .RESET(RESET), .CE(CE), .ACK(ACK), .ERR(ERR),
	.SGT_DIS(SGT_DIS), .SAVE_CSP(SAVE_CSP), .P0_OE(P0_OE), .P0_OUT(P0_OUT), .P4_OUT(P4_OUT), .ALE(ALE),
	.RD_N(RD_N), .WR_N(WR_N), .WRH_N(WRH_N));

// *** sim/ebu_mem_model.sv ***
// Behavioural memory on the far side of the bus.
`timescale 1ns/10ps
module ebu_mem_model
(
	// Clock and reset
	input wire        CLK,
	input wire        RESET,
	// Bench settings
	input wire [15:0] STRAP,
	input wire [2:0]  DLY,
	// Bus pins
	input wire [15:0] P0_OUT,
	input wire [15:0] P1_OUT,
	input wire        P1_OE,
	input wire [7:0]  P4_OUT,
	input wire        ALE,
	input wire        RD_N,
	input wire        WR_N,
	input wire        WRH_N,
	output reg [15:0] P0_IN,
	output reg        READY_N
);
	reg  [7:0]  mem_r [0:63];
	reg  [15:0] lat_r;
	reg  [2:0]  rc_r;
	reg  [2:0]  wt_r;
	// Segment bit 7 set marks the byte-wide device.
	wire [5:0]  addr = P1_OE ? P1_OUT[5:0] : lat_r[5:0];
	wire        wide = !P4_OUT[7];
	always @(negedge ALE)
		lat_r <= P0_OUT;
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			rc_r <= 3'h0;
		else if (rc_r != 3'h7)
			rc_r <= rc_r + 3'h1;
	end
	always @(posedge CLK)
	begin
		wt_r <= (RD_N && WR_N && WRH_N) ? 3'h0 : wt_r + {2'h0, wt_r != 3'h7};
		READY_N <= wt_r < DLY;
		if (RESET || rc_r != 3'h7)
			P0_IN <= STRAP;
		else if (!RD_N)
			P0_IN <= wide ? {mem_r[{addr[5:1], 1'b1}], mem_r[{addr[5:1], 1'b0}]} : {~P0_IN[15:8], mem_r[addr]};
		else
			P0_IN <= ~P0_IN;
		if (!WR_N)
			mem_r[wide ? {addr[5:1], 1'b0} : addr] <= P0_OUT[7:0];
		if (!WRH_N && wide)
			mem_r[{addr[5:1], 1'b1}] <= P0_OUT[15:8];
	end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the external bus cycle controller.
`timescale 1ns/10ps
module tb_top;
	reg         clk, rst, req, req_write, def_cfg_wr, sgt_dis, gerr, ce, ea_n, hold;
	reg  [23:0] req_addr, ad;
	reg  [1:0]  req_be;
	reg  [15:0] req_wdata, def_cfg_wdata, got;
	reg  [2:0]  dly;
	reg  [3:0]  gcs;
	wire [3:0]  cs_n;
	reg  [63:0] win_cfg, win_sel;
	reg  [31:0] rnd;
	wire        req_ready, ack, err, save_csp, single_chip, ready_n, p1_oe, ale, rd_n, wr_n, wrh_n;
	wire [15:0] rdata, def_cfg, p0_in, p0_out, p1_out;
	wire [7:0]  p4_out, p4_oe;
	integer     fails, checked, i;
	integer     cyc = 0;
	ebu_ctrl ebu_ctrl_inst (.CLK(clk), .RESET(rst), .CE(ce), .REQ(req), .REQ_ADDR(req_addr),
		.REQ_WRITE(req_write), .REQ_BE(req_be), .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .ACK(ack),
		.ERR(err), .RDATA(rdata), .WIN_CFG(win_cfg), .WIN_SEL(win_sel), .DEF_CFG_WR(def_cfg_wr),
		.DEF_CFG_WDATA(def_cfg_wdata), .DEF_CFG(def_cfg), .SGT_DIS(sgt_dis), .SAVE_CSP(save_csp),
		.SINGLE_CHIP(single_chip), .EA_N(ea_n), .HOLD(hold), .READY_N(ready_n), .P0_IN(p0_in),
		.P0_OUT(p0_out), .P0_OE(), .P1_OUT(p1_out), .P1_OE(p1_oe), .P4_OUT(p4_out), .P4_OE(p4_oe),
		.ALE(ale), .RD_N(rd_n), .WR_N(wr_n), .WRH_N(wrh_n), .CS_N(cs_n));
	// Serial port unused, so all eight segment lines may be strapped.
	ebu_mem_model ebu_mem_model_inst (.CLK(clk), .RESET(rst), .STRAP(16'h16C0), .DLY(dly), .P0_OUT(p0_out),
		.P1_OUT(p1_out), .P1_OE(p1_oe), .P4_OUT(p4_out), .ALE(ale), .RD_N(rd_n), .WR_N(wr_n),
		.WRH_N(wrh_n), .P0_IN(p0_in), .READY_N(ready_n));
	// ============================================================
	// Helpers
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [15:0] mix(input [15:0] old, input [15:0] nw, input [1:0] be);
		mix = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction
	task cmp(input [15:0] g, input [15:0] e);
	begin
		checked = checked + 1;
		if (g !== e)
		begin
			fails = fails + 1;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	end
	endtask
	// One request; the global cycle limit catches a hang.
	task access(input [23:0] a, input wr, input [1:0] be, input [15:0] wd);
	begin
		do @(negedge clk); while (req_ready !== 1'b1);
		req = 1'b1;
		req_addr = a;
		req_write = wr;
		req_be = be;
		req_wdata = wd;
		@(negedge clk);
		req = 1'b0;
		gcs = 4'hF;
		// A refusal answers at the taking edge, so look before waiting.
		while (ack !== 1'b1)
		begin
			gcs = gcs & cs_n;
			@(negedge clk);
		end
		got = rdata;
		gerr = err;
	end
	endtask
	task set_def(input [15:0] v);
	begin
		def_cfg_wr = 1'b1;
		def_cfg_wdata = v;
		@(negedge clk);
		def_cfg_wr = 1'b0;
		@(negedge clk);
	end
	endtask
	task finish_test;
	begin
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			fails = fails + 1;
			finish_test;
		end
	end
	// ============================================================
	// Main sequence
	initial
	begin
		fails = 0;
		checked = 0;
		{rst, req, req_write, def_cfg_wr, sgt_dis} = 5'h10;
		{ce, ea_n, hold} = 3'h4;
		{req_addr, req_be, req_wdata, def_cfg_wdata, dly} = 61'h0;
		rnd = 32'hfecf8ed4;
		// Window 0 byte-wide demux with ready and chip select, window 1 byte-wide multiplexed.
		win_cfg = {16'h0000, 16'h0000, 16'h0443, 16'h5403};
		win_sel = {16'hB000, 16'hA000, 16'h9000, 16'h8000};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		cmp(def_cfg, 16'h06CF);
		cmp({15'h0, single_chip}, 16'h0000);
		// A frozen clock enable must swallow a configuration write.
		ce = 1'b0;
		set_def(16'h0000);
		ce = 1'b1;
		cmp(def_cfg, 16'h06CF);
		for (i = 0; i < 12; i = i + 1)
		begin
			rnd = lfsr(rnd);
			ad = (i < 4 ? 24'h100000 : (i < 8 ? 24'h800000 : 24'h900000)) | {18'h0, rnd[4:0], 1'b0};
			dly = rnd[10:8];
			access(ad, 1'b1, 2'h3, rnd[31:16]);
			access(ad, 1'b0, 2'h3, 16'h0000);
			cmp(got, rnd[31:16]);
			cmp({15'h0, gerr}, 16'h0000);
			cmp({p4_oe, p4_out}, {8'hFF, ad[23:16]});
			cmp({12'h0, gcs}, (i >= 4 && i < 8) ? 16'h000E : 16'h000F);
		end
		for (i = 1; i < 3; i = i + 1)
		begin
			access(24'h100010, 1'b1, 2'h3, 16'h1234);
			access(24'h100010, 1'b1, i[1:0], 16'hABCD);
			access(24'h100010, 1'b0, 2'h3, 16'h0000);
			cmp(got, mix(16'h1234, 16'hABCD, i[1:0]));
		end
		// Default range without bus active must be refused.
		set_def(16'h0283);
		access(24'h100000, 1'b0, 2'h3, 16'h0000);
		cmp({15'h0, gerr}, 16'h0001);
		// Three waitstates cover the two-flop input latency of read data.
		set_def(16'h0683);
		cmp(def_cfg, 16'h0683);
		hold = 1'b1;
		repeat (4) @(negedge clk);
		cmp({14'h0, req_ready, rd_n & wr_n & wrh_n}, 16'h0001);
		hold = 1'b0;
		sgt_dis = 1'b1;
		for (i = 0; i < 2; i = i + 1)
		begin
			rnd = lfsr(rnd);
			access(24'h100020, 1'b1, 2'h3, rnd[15:0]);
			access(24'h100020, 1'b0, 2'h3, 16'h0000);
			cmp(got, rnd[15:0]);
			cmp({8'h0, p4_oe}, {8'h0, 8'hFF & {8{!sgt_dis}}});
			cmp({15'h0, save_csp}, {15'h0, !sgt_dis});
			sgt_dis = 1'b0;
		end
		// Second reset with the access pin high selects single chip operation.
		ea_n = 1'b1;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		cmp(def_cfg, 16'h02C0);
		cmp({15'h0, single_chip}, 16'h0001);
		access(24'h100000, 1'b0, 2'h3, 16'h0000);
		cmp({15'h0, gerr}, 16'h0001);
		finish_test;
	end
endmodule
